// ---- src/pulse_gen_output_and_approach.sv ----
// Output state selection and pulse width approach control.
// Assumes a register master on i_sys_clk, i_pulse_active from the pulse
// timer on the same clock, and the over-voltage event from outside.
//
// How it works
// [RULE_01] Code 32 forces the output low, code 33 forces it high.
// [RULE_02] Codes 55, 8d, aa give active-low, driven active-high, active-high pulses.
// [RULE_03] Any other code leaves the output floating.
// [RULE_04] Secondary output is held low unless the code is 8d.
// [RULE_05] Software sets approach enable in software mode; hardware owns it otherwise.
// [RULE_06] Mode select 0 is software, 1 hardware; rising clears timer, reloads counter.
// [RULE_07] In software mode target select picks register C or D.
// [RULE_08] Lock flag reads 1 while adjusting; preload A, M, N writes ignored.
// [RULE_09] Read-only phase field reports t0..t3 interval in hardware mode.
// [RULE_10] Done flags set on reaching C or D; software clears only.
// [RULE_11] Flags cleared on enable rise, over-voltage trigger, or timer enable rise.
// [RULE_12] Trigger source: over-voltage event at 0, timer enable rise at 1.
// [RULE_13] Field M paces steps: codes 01, 10, 11 give 2, 3, 4 triggers.
// [RULE_14] Field N sets step size 1 to 8 toward the target.
// [RULE_15] Times field limits changes of M and N to code plus one.
// [RULE_16] M change: 00/01 keep, 10 adds one, 11 subtracts one.
// [RULE_17] M at 00 or 11 never changes.
// [RULE_18] Hardware mode reverses change direction while approaching D.
// [RULE_19] N changes the same way and saturates at 111 and 000.
// [RULE_20] Timer enable starts the counter; writes ignored in hardware over-voltage mode.
// [RULE_21] Edge select: rising edge at 0, falling edge at 1.
// [RULE_22] Prescaler divides the clock by 128, 256, 512 or 1024.
`timescale 1ns/100ps
`include "pulse_gen_defines.svh"
module pulse_gen_output_and_approach #(
  parameter int DATA_W = 8,
  parameter int PSC_W = 10
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_overvoltage_event,
  input wire logic i_pulse_active,
  input wire logic i_secondary_pulse,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_pulse_out,
  output logic o_pulse_oe,
  output logic o_secondary_pulse_output,
  output logic [DATA_W-1:0] o_preload_a
);
  if (DATA_W != 8 || PSC_W < 10) begin : g_check
    $error("Only 8-bit data and a prescaler of at least 10 bits are supported");
  end

  function automatic logic [1:0] phase_of(input pulse_gen_pkg::phase_t s);
    case (s)
      pulse_gen_pkg::PH_FLOAT0: phase_of = 2'h0;
      pulse_gen_pkg::PH_TO_C: phase_of = 2'h1;
      pulse_gen_pkg::PH_TO_D: phase_of = 2'h2;
      default: phase_of = 2'h3;
    endcase
  endfunction : phase_of

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] code, pre_a, reg_c, reg_d, pre1, tcnt;
  logic sw_en, mode, tsel, done_c, done_d, trig_src, tmr_on, edge_sel;
  logic [1:0] m_cnt, m_chg, n_chg, psc, pace;
  logic [2:0] n_step, times;
  logic [3:0] chg_cnt;
  logic [PSC_W-1:0] psc_cnt;
  logic ov_s1, ov_s2, ov_s3, ov_lvl, ov_prev;
  pulse_gen_pkg::phase_t st;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_code = i_wr && i_addr == `PG_A_CODE;
  wire wr_ctrl = i_wr && i_addr == `PG_A_CTRL;
  wire wr_step = i_wr && i_addr == `PG_A_STEP;
  wire wr_chg = i_wr && i_addr == `PG_A_CHG;
  wire wr_tmc = i_wr && i_addr == `PG_A_TMC;
  wire wr_pre_a = i_wr && i_addr == `PG_A_PRE_A;

  // Over-voltage edge, taken once the last two stages agree
  wire ov_edge = ov_lvl != ov_prev && (ov_lvl ^ edge_sel); // see [RULE_21]

  wire ton_wr_ok = !(mode && !trig_src); // see [RULE_20]
  wire ton_rise = wr_tmc && ton_wr_ok && i_wdata[`PG_B_TON] && !tmr_on;
  wire hw_start = mode && (trig_src ? ton_rise : ov_edge); // see [RULE_12]
  wire sw_en_rise = !mode && wr_ctrl && i_wdata[`PG_B_EN] && !sw_en;
  wire mode_rise = wr_ctrl && i_wdata[`PG_B_MODE] && !mode; // see [RULE_06]
  wire flag_clr = sw_en_rise || (hw_start && !trig_src) || ton_rise; // see [RULE_11]

  wire hw_appr = st == pulse_gen_pkg::PH_TO_C || st == pulse_gen_pkg::PH_TO_D;
  wire en_read = mode ? hw_appr : sw_en; // see [RULE_05]
  wire use_d = mode ? st == pulse_gen_pkg::PH_TO_D : tsel; // see [RULE_07]
  wire [7:0] target = use_d ? reg_d : reg_c;
  wire adjusting = (mode ? hw_appr : sw_en) && pre_a != target;
  wire rev_dir = mode && st == pulse_gen_pkg::PH_TO_D; // see [RULE_18]

  // Prescaler: fH / (128 << code)
  wire [10:0] div = `PG_DIV_BASE << psc; // see [RULE_22]
  wire [PSC_W-1:0] psc_lim = PSC_W'(div - 11'h001);
  wire psc_tick = psc_cnt == psc_lim;

  // One step every M+1 triggers (code 00 steps on every trigger)
  wire step = psc_tick && adjusting && pace == 2'h0; // see [RULE_13]
  wire [3:0] step_amt = {1'b0, n_step} + 4'h1; // see [RULE_14]
  wire [8:0] sum_up = {1'b0, pre_a} + {5'h00, step_amt};
  wire [8:0] sum_dn = {1'b0, pre_a} - {5'h00, step_amt};
  wire go_up = pre_a < target;
  wire [7:0] a_up = sum_up > {1'b0, target} ? target : sum_up[7:0];
  wire [7:0] a_dn = sum_dn[8] || sum_dn < {1'b0, target} ? target : sum_dn[7:0];
  wire [7:0] next_pre_a = go_up ? a_up : a_dn;
  wire reached = step && next_pre_a == target;
  wire can_chg = step && chg_cnt <= {1'b0, times}; // see [RULE_15]

  wire m_inc = (m_chg == `PG_CHG_INC) ^ rev_dir; // see [RULE_16]
  wire n_inc = (n_chg == `PG_CHG_INC) ^ rev_dir;
  wire m_fixed = m_cnt == `PG_M_LOW || m_cnt == `PG_M_HIGH; // see [RULE_17]
  wire [1:0] m_moved = m_inc ? m_cnt + 2'h1 : m_cnt - 2'h1;
  wire [1:0] next_m = can_chg && m_chg[1] && !m_fixed ? m_moved : m_cnt;
  wire n_sat = n_inc ? n_step == `PG_N_MAX : n_step == `PG_N_MIN; // see [RULE_19]
  wire [2:0] n_moved = n_inc ? n_step + 3'h1 : n_step - 3'h1;
  wire [2:0] next_n = can_chg && n_chg[1] && !n_sat ? n_moved : n_step;

  wire tcnt_zero = tcnt == 8'h00;
  wire tcnt_exp = tmr_on && psc_tick && tcnt_zero;

  wire [7:0] ctrl_rd = {en_read, mode, tsel, adjusting, phase_of(st), done_c, done_d};
  wire [7:0] rd_mux =
    i_addr == `PG_A_CODE ? code :
    i_addr == `PG_A_CTRL ? ctrl_rd : // see [RULE_08] [RULE_09]
    i_addr == `PG_A_STEP ? {trig_src, 2'h0, m_cnt, n_step} :
    i_addr == `PG_A_CHG ? {1'b0, times, m_chg, n_chg} :
    i_addr == `PG_A_TMC ? {3'h0, tmr_on, edge_sel, 1'b0, psc} :
    i_addr == `PG_A_PRE_A ? pre_a :
    i_addr == `PG_A_REG_C ? reg_c :
    i_addr == `PG_A_REG_D ? reg_d :
    i_addr == `PG_A_PRE1 ? pre1 :
    i_addr == `PG_A_TCNT ? tcnt : `PG_RESET_BYTE;

  // Output state decode
  wire is_low = code == `PG_CODE_LOW;
  wire is_high = code == `PG_CODE_HIGH;
  wire is_alow = code == `PG_CODE_ACT_LOW;
  wire is_adrv = code == `PG_CODE_ACT_HI_DRV;
  wire is_ahi = code == `PG_CODE_ACT_HI;
  // Active-low code idles high and drops while the pulse timer is active
  wire next_out = is_high || (is_alow && !i_pulse_active) || // see [RULE_01] [RULE_02]
    ((is_adrv || is_ahi) && i_pulse_active);
  // Plain active-high code drives only while active; idle level floats
  wire next_oe = is_low || is_high || is_alow || is_adrv || (is_ahi && i_pulse_active); // see [RULE_03]
  wire next_sec = is_adrv && i_secondary_pulse; // see [RULE_04]

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ov_s1 <= 1'b0;
      ov_s2 <= 1'b0;
      ov_s3 <= 1'b0;
      ov_lvl <= 1'b0;
      ov_prev <= 1'b0;
    end else begin
      ov_s1 <= i_overvoltage_event;
      ov_s2 <= ov_s1;
      ov_s3 <= ov_s2;
      ov_prev <= ov_lvl;
      if (ov_s2 == ov_s3) begin
        ov_lvl <= ov_s3;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code <= `PG_RESET_BYTE;
      sw_en <= 1'b0;
      mode <= 1'b0;
      tsel <= 1'b0;
      trig_src <= 1'b0;
      m_chg <= 2'h0;
      n_chg <= 2'h0;
      times <= 3'h0;
      edge_sel <= 1'b0;
      psc <= 2'h0;
      reg_c <= `PG_RESET_BYTE;
      reg_d <= `PG_RESET_BYTE;
      pre1 <= `PG_RESET_BYTE;
    end else begin
      if (wr_code) begin
        code <= i_wdata;
      end
      if (wr_ctrl) begin
        mode <= i_wdata[`PG_B_MODE];
        tsel <= i_wdata[`PG_B_TSEL];
        if (!mode) begin
          sw_en <= i_wdata[`PG_B_EN]; // see [RULE_05]
        end
      end
      if (wr_step) begin
        trig_src <= i_wdata[`PG_B_TRIG];
      end
      if (wr_chg) begin
        times <= i_wdata[`PG_F_TIMES];
        m_chg <= i_wdata[`PG_F_MCHG];
        n_chg <= i_wdata[`PG_F_NCHG];
      end
      if (wr_tmc) begin
        edge_sel <= i_wdata[`PG_B_EDGE];
        psc <= i_wdata[`PG_F_PSC];
      end
      if (i_wr && i_addr == `PG_A_REG_C) begin
        reg_c <= i_wdata;
      end
      if (i_wr && i_addr == `PG_A_REG_D) begin
        reg_d <= i_wdata;
      end
      if (i_wr && i_addr == `PG_A_PRE1) begin
        pre1 <= i_wdata;
      end
    end
  end

  // Approach engine; a completion set wins over any clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_a <= `PG_RESET_BYTE;
      m_cnt <= 2'h0;
      n_step <= 3'h0;
      done_c <= 1'b0;
      done_d <= 1'b0;
      pace <= 2'h0;
      chg_cnt <= 4'h0;
      psc_cnt <= '0;
    end else begin
      psc_cnt <= psc_tick ? '0 : psc_cnt + 1'b1;
      if (step) begin
        pre_a <= next_pre_a;
      end else if (wr_pre_a && !adjusting) begin
        pre_a <= i_wdata; // see [RULE_08]
      end
      if (wr_step && !adjusting) begin
        m_cnt <= i_wdata[`PG_F_M];
        n_step <= i_wdata[`PG_F_N];
      end else begin
        m_cnt <= next_m;
        n_step <= next_n;
      end
      if (psc_tick && adjusting) begin
        pace <= pace == 2'h0 ? m_cnt : pace - 2'h1;
      end
      if (sw_en_rise || hw_start) begin
        chg_cnt <= 4'h0;
      end else if (can_chg) begin
        chg_cnt <= chg_cnt + 4'h1;
      end
      done_c <= (reached && !use_d) ||
        (done_c && !flag_clr && !(wr_ctrl && !i_wdata[`PG_B_DONE_C])); // see [RULE_10]
      done_d <= (reached && use_d) ||
        (done_d && !flag_clr && !(wr_ctrl && !i_wdata[`PG_B_DONE_D]));
    end
  end

  // Approach timer and hardware phase sequence
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_on <= 1'b0;
      tcnt <= `PG_RESET_BYTE;
      st <= pulse_gen_pkg::PH_FLOAT0;
    end else begin
      if (mode_rise) begin
        tmr_on <= 1'b0;
        tcnt <= pre1;
        st <= pulse_gen_pkg::PH_FLOAT0;
      end else if (hw_start || ton_rise) begin
        tmr_on <= 1'b1;
        tcnt <= pre1;
        st <= pulse_gen_pkg::PH_FLOAT0;
      end else begin
        if (wr_tmc && ton_wr_ok) begin
          tmr_on <= i_wdata[`PG_B_TON]; // see [RULE_20]
        end
        if (tcnt_exp) begin
          tcnt <= pre1;
          if (mode) begin
            case (st)
              pulse_gen_pkg::PH_FLOAT0: st <= pulse_gen_pkg::PH_TO_C;
              pulse_gen_pkg::PH_TO_C: st <= pulse_gen_pkg::PH_TO_D;
              pulse_gen_pkg::PH_TO_D: st <= pulse_gen_pkg::PH_FLOAT3;
              default: st <= pulse_gen_pkg::PH_FLOAT0;
            endcase
          end
        end else if (tmr_on && psc_tick) begin
          tcnt <= tcnt - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `PG_RESET_BYTE;
      o_pulse_out <= 1'b0;
      o_pulse_oe <= 1'b0;
      o_secondary_pulse_output <= 1'b0;
      o_preload_a <= `PG_RESET_BYTE;
    end else begin
      o_rdata <= i_rd ? rd_mux : `PG_RESET_BYTE;
      o_pulse_out <= next_out;
      o_pulse_oe <= next_oe;
      o_secondary_pulse_output <= next_sec;
      o_preload_a <= pre_a;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  force_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_01]
    is_low |=> o_pulse_oe && !o_pulse_out) else $error("forced low not driven low");
  act_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_02]
    is_alow && i_pulse_active |=> o_pulse_oe && !o_pulse_out)
    else $error("active low pulse wrong");
  act_low_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_02]
    is_alow && !i_pulse_active |=> o_pulse_oe && o_pulse_out)
    else $error("active low pulse idle level wrong");
  float_other_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_03]
    !(is_low || is_high || is_alow || is_adrv || is_ahi) |=> !o_pulse_oe)
    else $error("undefined code drives output");
  sec_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_04]
    !is_adrv |=> !o_secondary_pulse_output) else $error("secondary output not low");
  hw_en_ignore_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_05]
    mode && wr_ctrl |=> $stable(sw_en)) else $error("enable written in hardware mode");
  mode_rise_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_06]
    mode_rise |=> !tmr_on && tcnt == $past(pre1)) else $error("mode rise no reload");
  lock_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_08]
    wr_pre_a && adjusting && !step |=> $stable(pre_a)) else $error("locked preload changed");
  done_sw_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_10]
    !done_c && !reached ##1 1'b1 |-> !done_c) else $error("done flag set without reach");
  n_sat_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_19]
    n_step == `PG_N_MAX && !wr_step && n_inc |=> n_step == `PG_N_MAX)
    else $error("step field wrapped");
  ton_ignore_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [RULE_20]
    mode && !trig_src && wr_tmc && !ov_edge && !mode_rise |=> $stable(tmr_on))
    else $error("timer enable written in over-voltage mode");
endmodule : pulse_gen_output_and_approach

// ---- src/pulse_gen_defines.svh ----
// Constants for the pulse generator output and approach block.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef PULSE_GEN_DEFINES_SVH
`define PULSE_GEN_DEFINES_SVH
// ----------------------------------------
// Register addresses (index on the plain port)
// ----------------------------------------
`define PG_A_CODE 4'h0
`define PG_A_CTRL 4'h1
`define PG_A_STEP 4'h2
`define PG_A_CHG 4'h3
`define PG_A_TMC 4'h4
`define PG_A_PRE_A 4'h5
`define PG_A_REG_C 4'h6
`define PG_A_REG_D 4'h7
`define PG_A_PRE1 4'h8
`define PG_A_TCNT 4'h9
`define PG_RESET_BYTE 8'h00
// ----------------------------------------
// Output control codes
// ----------------------------------------
`define PG_CODE_LOW 8'h32
`define PG_CODE_HIGH 8'h33
`define PG_CODE_ACT_LOW 8'h55
`define PG_CODE_ACT_HI_DRV 8'h8d
`define PG_CODE_ACT_HI 8'haa
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PG_B_EN 7
`define PG_B_MODE 6
`define PG_B_TSEL 5
`define PG_B_LOCK 4
`define PG_B_DONE_C 1
`define PG_B_DONE_D 0
`define PG_B_TRIG 7
`define PG_B_TON 4
`define PG_B_EDGE 3
`define PG_F_TIMES 6:4
`define PG_F_MCHG 3:2
`define PG_F_NCHG 1:0
`define PG_F_PSC 1:0
`define PG_F_M 4:3
`define PG_F_N 2:0
`define PG_CHG_INC 2'b10
`define PG_CHG_DEC 2'b11
`define PG_M_LOW 2'b00
`define PG_M_HIGH 2'b11
`define PG_N_MAX 3'h7
`define PG_N_MIN 3'h0
// High-speed clock divided by 128 << prescaler code
`define PG_DIV_BASE 11'h080
`endif

// ---- src/pulse_gen_pkg.sv ----
// Types shared by the pulse generator output and approach block.
// Assumes nothing beyond a SystemVerilog compiler.
package pulse_gen_pkg;
  // Gray-coded approach sequence t0 -> t1 -> t2 -> t3
  typedef enum logic [1:0] {
    PH_FLOAT0 = 2'b00,
    PH_TO_C = 2'b01,
    PH_TO_D = 2'b11,
    PH_FLOAT3 = 2'b10
  } phase_t;
endpackage : pulse_gen_pkg

// ---- dv/power_stage_model.sv ----
// Power stage model: gate pin with a pull-down and an over-voltage sense.
// Assumes the bench raises i_trip to stand for a supply surge.
`timescale 1ns/100ps
module power_stage_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_trip,
  input wire logic i_gate_drive,
  input wire logic i_gate_oe,
  output logic o_overvoltage,
  output logic o_gate_level
);
  // ----------------------------------------
  // Gate pin and surge sense
  // ----------------------------------------
  logic [1:0] sense;
  // Floating gate is pulled down so the switch stays off
  assign o_gate_level = i_gate_oe ? i_gate_drive : 1'b0;
  // Comparator lag of two cycles before a surge shows
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sense <= 2'b00;
    end else begin
      sense <= {sense[0], i_trip};
    end
  end
  assign o_overvoltage = sense[1];
endmodule : power_stage_model

// ---- dv/pulse_gen_output_and_approach_tb.sv ----
// Self-checking bench for the pulse generator output and approach block.
// Assumes the design under src/ and the power stage model under dv/.
`timescale 1ns/100ps
`include "pulse_gen_defines.svh"
module pulse_gen_output_and_approach_tb;
  logic i_sys_clk, i_rst_n, i_wr, i_rd, i_pulse_active, i_secondary_pulse, trip;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_preload_a, rv, code;
  logic o_pulse_out, o_pulse_oe, o_secondary_pulse_output, ov, gate;
  logic [2:0] ex;
  logic [7:0] tbl [5] = '{8'h32, 8'h33, 8'h55, 8'h8d, 8'haa};
  int errors, compares, seed, cycles;
  wire [7:0] pins = {5'h0, o_pulse_oe, o_pulse_out, o_secondary_pulse_output};

  pulse_gen_output_and_approach DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_overvoltage_event(ov), .i_pulse_active(i_pulse_active),
    .i_secondary_pulse(i_secondary_pulse), .o_rdata(o_rdata), .o_pulse_out(o_pulse_out),
    .o_pulse_oe(o_pulse_oe), .o_secondary_pulse_output(o_secondary_pulse_output),
    .o_preload_a(o_preload_a));
  power_stage_model stage (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_trip(trip),
    .i_gate_drive(o_pulse_out), .i_gate_oe(o_pulse_oe), .o_overvoltage(ov),
    .o_gate_level(gate));

  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  // Bounded poll of the control register for a masked value
  task automatic wait_ctrl(input logic [7:0] mask, input logic [7:0] val);
    for (int n = 0; n < 800; n++) begin
      rd(`PG_A_CTRL, rv);
      if ((rv & mask) == val) break;
      repeat (6) @(posedge i_sys_clk);
    end
  endtask : wait_ctrl

  // Returns {drive enable, pin level, secondary output}
  function automatic logic [2:0] exp_pin(input logic [7:0] c, input logic act, input logic s);
    case (c)
      8'h32: exp_pin = 3'b100;
      8'h33: exp_pin = 3'b110;
      8'h55: exp_pin = {2'b10 | {1'b0, ~act}, 1'b0};
      8'h8d: exp_pin = {1'b1, act, s};
      8'haa: exp_pin = {act, act, 1'b0};
      default: exp_pin = 3'b000;
    endcase
  endfunction : exp_pin

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h39eb;
    errors = 0;
    compares = 0;
    cycles = 0;
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_pulse_active = 1'b0;
    i_secondary_pulse = 1'b0;
    trip = 1'b0;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      rd(a[3:0], rv);
      chk("reset value", 8'h00, rv);
    end
    wr(4'hf, 8'h5a);
    rd(4'hf, rv);
    chk("unmapped read", 8'h00, rv);
    // Defined codes first, then random ones that mostly float
    for (int k = 0; k < 14; k++) begin
      code = (k < 5) ? tbl[k] : 8'($random(seed));
      @(posedge i_sys_clk);
      i_pulse_active <= 1'($random(seed));
      i_secondary_pulse <= 1'($random(seed));
      wr(`PG_A_CODE, code);
      repeat (2) @(posedge i_sys_clk);
      #1;
      ex = exp_pin(code, i_pulse_active, i_secondary_pulse);
      chk("pin state", {5'h0, ex}, pins);
      chk("gate level", {7'h0, ex[2] & ex[1]}, {7'h0, gate});
      rd(`PG_A_CODE, rv);
      chk("code register", code, rv);
    end
    wr(`PG_A_CTRL, 8'h03);
    rd(`PG_A_CTRL, rv);
    chk("done flags set by write", 8'h00, rv);
    // Software approach toward C, then D
    wr(`PG_A_PRE_A, 8'h0a);
    wr(`PG_A_REG_C, 8'h28);
    wr(`PG_A_REG_D, 8'h05);
    wr(`PG_A_STEP, 8'h02);
    wr(`PG_A_TMC, 8'h00);
    wr(`PG_A_CTRL, 8'h80);
    rd(`PG_A_CTRL, rv);
    chk("lock flag", 8'h90, rv & 8'hf0);
    wr(`PG_A_PRE_A, 8'h99);
    wr(`PG_A_STEP, 8'h07);
    rd(`PG_A_STEP, rv);
    chk("locked step field", 8'h02, rv);
    for (int n = 0; n < 2000 && o_preload_a === 8'h0a; n++) @(posedge i_sys_clk);
    #1;
    chk("first step", 8'h0d, o_preload_a);
    wait_ctrl(8'h02, 8'h02);
    chk("done C", 8'h02, rv & 8'h02);
    chk("reached C", 8'h28, o_preload_a);
    wr(`PG_A_CTRL, 8'h01);
    rd(`PG_A_CTRL, rv);
    chk("software clear", 8'h00, rv & 8'h03);
    wr(`PG_A_CTRL, 8'ha1);
    wait_ctrl(8'h01, 8'h01);
    chk("done D", 8'h01, rv & 8'h01);
    chk("reached D", 8'h05, o_preload_a);
    // M from 01 climbs to 11 and sticks, N from 110 saturates at 111
    wr(`PG_A_CTRL, 8'h01);
    wr(`PG_A_CHG, 8'h7a);
    wr(`PG_A_STEP, 8'h0e);
    wr(`PG_A_REG_D, 8'h40);
    wr(`PG_A_CTRL, 8'ha1);
    wait_ctrl(8'h01, 8'h01);
    chk("reached D again", 8'h40, o_preload_a);
    rd(`PG_A_STEP, rv);
    chk("M and N changed", 8'h1f, rv);
    // Hardware mode started by a rising over-voltage edge
    wr(`PG_A_CTRL, 8'h01);
    wr(`PG_A_PRE1, 8'h01);
    wr(`PG_A_CTRL, 8'h41);
    @(posedge i_sys_clk);
    trip <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    rd(`PG_A_CTRL, rv);
    chk("trigger clears done", 8'h40, rv & 8'h4f);
    wait_ctrl(8'h0c, 8'h04);
    chk("phase to C", 8'h04, rv & 8'h0c);
    wait_ctrl(8'h0c, 8'h08);
    chk("phase to D", 8'h08, rv & 8'h0c);
    trip <= 1'b0;
    // Timer enable ownership
    wr(`PG_A_CTRL, 8'h00);
    wr(`PG_A_STEP, 8'h80);
    wr(`PG_A_TMC, 8'h10);
    rd(`PG_A_TMC, rv);
    chk("timer enable", 8'h10, rv);
    wr(`PG_A_CTRL, 8'h40);
    rd(`PG_A_TMC, rv);
    chk("mode rise", 8'h00, rv);
    wr(`PG_A_STEP, 8'h00);
    wr(`PG_A_TMC, 8'h1b);
    rd(`PG_A_TMC, rv);
    chk("timer write ignored", 8'h0b, rv);
    give_verdict();
  end
endmodule : pulse_gen_output_and_approach_tb
